//--- rtl/ssms_pkg.sv
// Constants shared by the socket mask and present-state register bank
`default_nettype none
package ssms_pkg;
   // ==========================================================
   // Bus widths and offsets
   localparam int SSMS_DATA_W = 32;
   localparam int SSMS_ADDR_W = 8;
   localparam logic [SSMS_ADDR_W-1:0] SSMS_MASK_OFFSET = 8'h04;
   localparam logic [SSMS_ADDR_W-1:0] SSMS_STATE_OFFSET = 8'h08;
   localparam logic [SSMS_DATA_W-1:0] SSMS_ZERO_WORD = 32'h0000_0000;
   // ==========================================================
   // Mask register layout
   localparam int SSMS_MASK_W = 4;
   localparam int SSMS_MASK_STS = 0;
   localparam int SSMS_MASK_CD_LO = 1;
   localparam int SSMS_MASK_CD_HI = 2;
   localparam int SSMS_MASK_PWR = 3;
   localparam logic [SSMS_MASK_W-1:0] SSMS_MASK_RESET = 4'h0;
   localparam logic [1:0] SSMS_CD_ENABLE = 2'h3;
   // ==========================================================
   // Event bit layout (event register lives outside)
   localparam int SSMS_EVENT_W = 4;
   localparam int SSMS_EV_STS = 0;
   localparam int SSMS_EV_CD1 = 1;
   localparam int SSMS_EV_CD2 = 2;
   localparam int SSMS_EV_PWR = 3;
   // ==========================================================
   // Present-state layout
   localparam int SSMS_PS_YY_SOCK = 31;
   localparam int SSMS_PS_XX_SOCK = 30;
   localparam int SSMS_PS_3V3_SOCK = 29;
   localparam int SSMS_PS_5V_SOCK = 28;
   localparam int SSMS_PS_RSVD_HI = 27;
   localparam int SSMS_PS_RSVD_LO = 14;
   localparam int SSMS_PS_VOLT_HI = 13;
   localparam int SSMS_PS_VOLT_LO = 10;
   localparam int SSMS_PS_BADV = 9;
   localparam int SSMS_PS_LOSS = 8;
   localparam int SSMS_PS_NOTCARD = 7;
   localparam int SSMS_PS_READY = 6;
   localparam int SSMS_PS_CB = 5;
   localparam int SSMS_PS_16 = 4;
   localparam int SSMS_PS_PWR = 3;
   localparam int SSMS_PS_CD2 = 2;
   localparam int SSMS_PS_CD1 = 1;
   localparam int SSMS_PS_STS = 0;
   localparam int SSMS_VOLT_W = 4;
   localparam logic SSMS_YY_SOCK_RESET = 1'h0;
   localparam logic SSMS_XX_SOCK_RESET = 1'h0;
   localparam logic SSMS_3V3_SOCK_RESET = 1'h1;
   localparam int SSMS_RSVD_W = 14;
   // ==========================================================
   // Pin synchroniser lanes
   localparam int SSMS_PIN_W = 5;
   localparam int SSMS_PIN_CD1 = 0;
   localparam int SSMS_PIN_CD2 = 1;
   localparam int SSMS_PIN_STS = 2;
   localparam int SSMS_PIN_READY = 3;
   localparam int SSMS_PIN_PCI_BUS_RESET = 4;
   localparam logic [SSMS_PIN_W-1:0] SSMS_PIN_RESET = 5'h1f;
endpackage : ssms_pkg
`default_nettype wire

//--- rtl/ssms_sync.sv
// Two-flop synchroniser for socket pins
`default_nettype none
module ssms_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] synced
);
   // ==========================================================
   // Per-bit double flop; first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_lane
         logic stage1;
         logic stage2;
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               stage1 <= RESET_VAL[i];
               stage2 <= RESET_VAL[i];
            end else begin
               stage1 <= pin[i];
               stage2 <= stage1;
            end
         end
         assign synced[i] = stage2; // One driver per lane bit
      end
   endgenerate
endmodule : ssms_sync
`default_nettype wire

//--- rtl/ssms_mask_reg.sv
// Socket interrupt mask with power-management context clearing
`default_nettype none
module ssms_mask_reg
   import ssms_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic bus_reset,
   input wire logic pme_enable,
   input wire logic wr_en,
   input wire logic [ssms_pkg::SSMS_MASK_W-1:0] wr_data,
   output logic [ssms_pkg::SSMS_MASK_W-1:0] mask
);
   // ==========================================================
   // Clear selection
   wire ctx_clear = bus_reset && !pme_enable; // Context bits keep state across bus reset under PME
   wire [SSMS_MASK_W-1:0] next_mask;
   assign next_mask[SSMS_MASK_PWR] = bus_reset ? SSMS_MASK_RESET[SSMS_MASK_PWR] :
                                     wr_en ? wr_data[SSMS_MASK_PWR] : mask[SSMS_MASK_PWR];
   assign next_mask[SSMS_MASK_CD_HI:SSMS_MASK_STS] = ctx_clear ?
                                     SSMS_MASK_RESET[SSMS_MASK_CD_HI:SSMS_MASK_STS] :
                                     wr_en ? wr_data[SSMS_MASK_CD_HI:SSMS_MASK_STS] :
                                     mask[SSMS_MASK_CD_HI:SSMS_MASK_STS];

   // Global reset clears everything
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mask <= SSMS_MASK_RESET;
      end else begin
         mask <= next_mask;
      end
   end

   // ==========================================================
   // Checks
   ctx_keep_a: assert property (@(posedge clock) disable iff (!rst_b)
      (bus_reset && pme_enable && !wr_en) |=> $stable(mask[SSMS_MASK_CD_HI:SSMS_MASK_STS]))
      else $error("context mask bits lost on bus reset with PME enabled");
   ctx_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      (bus_reset && !pme_enable) |=> mask == SSMS_MASK_RESET)
      else $error("mask not cleared by bus reset with PME disabled");
endmodule : ssms_mask_reg
`default_nettype wire

//--- rtl/ssms_top.sv
// Socket interrupt mask and present-state register bank
`default_nettype none
module ssms_top
   import ssms_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic pci_bus_reset_b,
   input wire logic pme_enable,
   input wire logic [ssms_pkg::SSMS_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ssms_pkg::SSMS_DATA_W-1:0] reg_wr_data,
   output logic [ssms_pkg::SSMS_DATA_W-1:0] reg_rd_data,
   input wire logic [ssms_pkg::SSMS_EVENT_W-1:0] event_bits,
   input wire logic force_wr,
   input wire logic [ssms_pkg::SSMS_DATA_W-1:0] force_data,
   input wire logic five_volt_override,
   input wire logic card_inserted,
   input wire logic interrogating,
   input wire logic [ssms_pkg::SSMS_VOLT_W-1:0] sensed_card_volts,
   input wire logic sensed_cardbus_card,
   input wire logic sensed_16bit_card,
   input wire logic sensed_not_a_card,
   input wire logic socket_powered_flag,
   input wire logic invalid_supply_request,
   input wire logic removal_data_loss,
   input wire logic detect_line_one_pin,
   input wire logic detect_line_two_pin,
   input wire logic status_change_line_pin,
   input wire logic ready_line_pin,
   output logic socket_change_interrupt
);
   // ==========================================================
   // Pin synchronisation
   logic [SSMS_PIN_W-1:0] pin_sync;
   ssms_sync #(
      .WIDTH(SSMS_PIN_W),
      .RESET_VAL(SSMS_PIN_RESET)
   ) u_pin_sync (
      .clock(clock),
      .rst_b(rst_b),
      .pin({!pci_bus_reset_b, ready_line_pin, status_change_line_pin, detect_line_two_pin, detect_line_one_pin}),
      .synced(pin_sync)
   );
   // Bus reset is trusted only after the synchroniser has filled with real samples
   logic pci_bus_seen;
   logic [1:0] settle;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         settle <= 2'h0;
         pci_bus_seen <= 1'h0;
      end else begin
         settle <= {settle[0], 1'h1};
         pci_bus_seen <= settle[1];
      end
   end

   // Bus reset lane resets to its active level; the settle gate hides that until real samples arrive
   wire bus_reset = pin_sync[SSMS_PIN_PCI_BUS_RESET] && pci_bus_seen;
   wire ctx_clear = bus_reset && !pme_enable;
   wire status_change_line_state = pin_sync[SSMS_PIN_STS];
   wire ready_line_state = pin_sync[SSMS_PIN_READY];

   // ==========================================================
   // Mask register
   logic [SSMS_MASK_W-1:0] mask;
   wire mask_hit = reg_addr == SSMS_MASK_OFFSET;
   wire state_hit = reg_addr == SSMS_STATE_OFFSET;
   ssms_mask_reg u_mask (
      .clock(clock),
      .rst_b(rst_b),
      .bus_reset(bus_reset),
      .pme_enable(pme_enable),
      .wr_en(reg_wr && mask_hit),
      .wr_data(reg_wr_data[SSMS_MASK_W-1:0]),
      .mask(mask)
   );
   wire power_cycle_irq_enable = mask[SSMS_MASK_PWR];
   wire [1:0] card_detect_irq_enable = mask[SSMS_MASK_CD_HI:SSMS_MASK_CD_LO];
   wire status_change_irq_enable = mask[SSMS_MASK_STS];
   // Only the full 11 code opens detect events; reserved codes stay closed
   wire cd_open = card_detect_irq_enable == SSMS_CD_ENABLE;

   // ==========================================================
   // Interrupt gating; event bits are set elsewhere and are never touched by the mask
   wire [SSMS_EVENT_W-1:0] event_enable = {power_cycle_irq_enable, cd_open, cd_open, status_change_irq_enable};
   wire next_irq = |(event_bits & event_enable);
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         socket_change_interrupt <= 1'h0;
      end else begin
         socket_change_interrupt <= next_irq;
      end
   end

   // ==========================================================
   // Socket capability bits; YY, XX and 3.3 V overridable by force writes, 5 V cleared by five_volt_override
   logic socket_supports_yy_volt;
   logic socket_supports_xx_volt;
   logic socket_supports_3v3;
   wire socket_supports_5v = !five_volt_override;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         socket_supports_yy_volt <= SSMS_YY_SOCK_RESET;
         socket_supports_xx_volt <= SSMS_XX_SOCK_RESET;
         socket_supports_3v3 <= SSMS_3V3_SOCK_RESET;
      end else if (bus_reset) begin
         socket_supports_yy_volt <= SSMS_YY_SOCK_RESET;
         socket_supports_xx_volt <= SSMS_XX_SOCK_RESET;
         socket_supports_3v3 <= SSMS_3V3_SOCK_RESET;
      end else if (force_wr) begin
         socket_supports_yy_volt <= force_data[SSMS_PS_YY_SOCK];
         socket_supports_xx_volt <= force_data[SSMS_PS_XX_SOCK];
         socket_supports_3v3 <= force_data[SSMS_PS_3V3_SOCK];
      end
   end

   // ==========================================================
   // Card voltage and type: loaded at insertion; forced voltage bits OR in, forced type bits replace the type
   logic [SSMS_VOLT_W-1:0] card_volts;
   logic cardbus_card;
   logic bit16_card;
   logic not_a_card;
   wire [SSMS_VOLT_W-1:0] forced_volts = force_wr ? force_data[SSMS_PS_VOLT_HI:SSMS_PS_VOLT_LO] : 4'h0;
   wire [SSMS_VOLT_W-1:0] next_card_volts = (card_inserted ? sensed_card_volts : card_volts) | forced_volts;
   wire next_cardbus = force_wr ? force_data[SSMS_PS_CB] : card_inserted ? sensed_cardbus_card : cardbus_card;
   wire next_16bit = force_wr ? force_data[SSMS_PS_16] : card_inserted ? sensed_16bit_card : bit16_card;
   wire next_notcard = force_wr ? force_data[SSMS_PS_NOTCARD] : card_inserted ? sensed_not_a_card : not_a_card;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         card_volts <= 4'h0;
         cardbus_card <= 1'h0;
         bit16_card <= 1'h0;
         not_a_card <= 1'h0;
      end else if (ctx_clear) begin
         card_volts <= 4'h0;
         cardbus_card <= 1'h0;
         bit16_card <= 1'h0;
         not_a_card <= 1'h0;
      end else begin
         card_volts <= next_card_volts;
         cardbus_card <= next_cardbus;
         bit16_card <= next_16bit;
         not_a_card <= next_notcard;
      end
   end

   // ==========================================================
   // Sticky fault flags: a setting event beats a force write of zero
   logic invalid_supply_request_flag;
   logic removal_data_loss_flag;
   wire next_badv = invalid_supply_request ||
                    (force_wr ? force_data[SSMS_PS_BADV] : invalid_supply_request_flag);
   wire next_loss = removal_data_loss ||
                    (force_wr ? force_data[SSMS_PS_LOSS] : removal_data_loss_flag);
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         invalid_supply_request_flag <= 1'h0;
         removal_data_loss_flag <= 1'h0;
      end else if (ctx_clear) begin
         invalid_supply_request_flag <= 1'h0;
         removal_data_loss_flag <= 1'h0;
      end else begin
         invalid_supply_request_flag <= next_badv;
         removal_data_loss_flag <= next_loss;
      end
   end

   // ==========================================================
   // Detect lines frozen while the card is being identified
   logic detect_line_one_state;
   logic detect_line_two_state;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         detect_line_one_state <= 1'h0;
         detect_line_two_state <= 1'h0;
      end else if (ctx_clear) begin
         detect_line_one_state <= 1'h0;
         detect_line_two_state <= 1'h0;
      end else if (!interrogating) begin
         detect_line_one_state <= pin_sync[SSMS_PIN_CD1];
         detect_line_two_state <= pin_sync[SSMS_PIN_CD2];
      end
   end

   // ==========================================================
   // Present-state word and read mux
   wire [SSMS_DATA_W-1:0] state_word = {socket_supports_yy_volt, socket_supports_xx_volt, socket_supports_3v3,
                                        socket_supports_5v, {SSMS_RSVD_W{1'b0}}, card_volts,
                                        invalid_supply_request_flag, removal_data_loss_flag, not_a_card,
                                        ready_line_state, cardbus_card, bit16_card, socket_powered_flag,
                                        detect_line_two_state, detect_line_one_state,
                                        status_change_line_state};
   wire [SSMS_DATA_W-1:0] mask_word = {{(SSMS_DATA_W-SSMS_MASK_W){1'b0}}, mask};
   // Unmapped offsets answer zero rather than holding stale data
   wire [SSMS_DATA_W-1:0] next_rd_data = mask_hit ? mask_word : state_hit ? state_word : SSMS_ZERO_WORD;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reg_rd_data <= SSMS_ZERO_WORD;
      end else if (reg_rd) begin
         reg_rd_data <= next_rd_data;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence mask_read_s;
      reg_rd && mask_hit;
   endsequence
   sequence state_read_s;
      reg_rd && state_hit;
   endsequence
   // Pins must sit still long enough to flush the synchroniser's reset values
   sequence sts_steady_s;
      $stable(status_change_line_pin) [*4];
   endsequence
   sequence rdy_steady_s;
      $stable(ready_line_pin) [*4];
   endsequence
   sequence force_s;
      force_wr && !ctx_clear;
   endsequence
   sequence insert_s;
      card_inserted && !force_wr && !ctx_clear;
   endsequence

   mask_read_a: assert property (mask_read_s |=> reg_rd_data == {28'h0000000, $past(mask)})
      else $error("mask read shows wrong or nonzero reserved bits");
   state_resv_a: assert property (state_read_s |=> reg_rd_data[SSMS_PS_RSVD_HI:SSMS_PS_RSVD_LO] == 14'h0000)
      else $error("present-state reserved bits not zero");
   five_volt_a: assert property (state_read_s
      |=> reg_rd_data[SSMS_PS_5V_SOCK] == !$past(five_volt_override))
      else $error("5 V socket bit does not follow override");
   pwr_gate_a: assert property (event_bits == 4'h8 |=> socket_change_interrupt == $past(mask[SSMS_MASK_PWR]))
      else $error("power-cycle interrupt gating wrong");
   sts_gate_a: assert property (event_bits == 4'h1 |=> socket_change_interrupt == $past(mask[SSMS_MASK_STS]))
      else $error("status-change interrupt gating wrong");
   cd_gate_a: assert property ((event_bits == 4'h6) |=> socket_change_interrupt == ($past(mask[2:1]) == 2'h3))
      else $error("detect interrupt not gated by full 11 code");
   cd_rsvd_a: assert property ((!event_bits[SSMS_EV_PWR] && !event_bits[SSMS_EV_STS]
      && card_detect_irq_enable != SSMS_CD_ENABLE) |=> !socket_change_interrupt)
      else $error("reserved detect code raised interrupt");
   irq_none_a: assert property ((event_bits == 4'h0)[*2] |=> !socket_change_interrupt)
      else $error("interrupt without any event");
   sts_live_a: assert property (sts_steady_s |-> state_word[SSMS_PS_STS] == status_change_line_pin)
      else $error("status bit does not follow the line");
   detect_hold_a: assert property (interrogating && !ctx_clear
      |=> $stable({detect_line_one_state, detect_line_two_state}))
      else $error("detect state changed during identification");
   volts_hold_a: assert property ((!card_inserted && !force_wr && !ctx_clear) |=> $stable(card_volts))
      else $error("card voltage bits changed without insertion");
   force_volt_a: assert property ((force_wr && !ctx_clear) |=> (card_volts & $past(forced_volts)) == $past(forced_volts))
      else $error("forced card voltage bit not set");
   socket_hold_a: assert property ((!force_wr && !bus_reset)
      |=> $stable({socket_supports_yy_volt, socket_supports_xx_volt, socket_supports_3v3}))
      else $error("socket capability changed without force write");
   fault_set_a: assert property ((removal_data_loss && !ctx_clear) |=> removal_data_loss_flag)
      else $error("data loss flag not set on its event");
   badv_set_a: assert property ((invalid_supply_request && !ctx_clear) |=> invalid_supply_request_flag)
      else $error("bad supply flag not set on its event");

   // ==========================================================
   // Register path, card type and socket default checks
   mask_write_a: assert property ((reg_wr && mask_hit && !bus_reset)
      |=> mask == $past(reg_wr_data[SSMS_MASK_W-1:0]))
      else $error("mask write did not land");
   read_hold_a: assert property (!reg_rd |=> $stable(reg_rd_data))
      else $error("read data changed without a read");
   unmapped_zero_a: assert property ((reg_rd && !mask_hit && !state_hit) |=> reg_rd_data == SSMS_ZERO_WORD)
      else $error("unmapped read not zero");
   powered_read_a: assert property (state_read_s
      |=> reg_rd_data[SSMS_PS_PWR] == $past(socket_powered_flag))
      else $error("powered bit read wrong");
   ready_live_a: assert property (rdy_steady_s |-> state_word[SSMS_PS_READY] == ready_line_pin)
      else $error("ready bit does not follow the line");
   type_force_a: assert property (force_s |=> not_a_card == $past(force_data[SSMS_PS_NOTCARD])
      && cardbus_card == $past(force_data[SSMS_PS_CB]) && bit16_card == $past(force_data[SSMS_PS_16]))
      else $error("forced card type not shown");
   type_insert_a: assert property (insert_s |=> not_a_card == $past(sensed_not_a_card)
      && cardbus_card == $past(sensed_cardbus_card) && bit16_card == $past(sensed_16bit_card))
      else $error("card type not loaded at insertion");
   volt_insert_a: assert property (insert_s |=> card_volts == $past(sensed_card_volts))
      else $error("card voltage bits not loaded at insertion");
   type_hold_a: assert property ((!card_inserted && !force_wr && !ctx_clear)
      |=> $stable({not_a_card, cardbus_card, bit16_card}))
      else $error("card type changed without insertion");
   socket_force_a: assert property ((force_wr && !bus_reset)
      |=> {socket_supports_yy_volt, socket_supports_xx_volt, socket_supports_3v3}
          == $past(force_data[SSMS_PS_YY_SOCK:SSMS_PS_3V3_SOCK]))
      else $error("force write did not reach socket capability");
   socket_dflt_a: assert property (bus_reset
      |=> {socket_supports_yy_volt, socket_supports_xx_volt, socket_supports_3v3}
          == {SSMS_YY_SOCK_RESET, SSMS_XX_SOCK_RESET, SSMS_3V3_SOCK_RESET})
      else $error("socket capability not restored by bus reset");
   card_clear_a: assert property ((bus_reset && !pme_enable)
      |=> card_volts == 4'h0 && !invalid_supply_request_flag && !removal_data_loss_flag)
      else $error("context state kept across bus reset with PME disabled");
endmodule : ssms_top
`default_nettype wire

//--- verification/ssms_card_model.sv
// Behavioural card sitting in the socket: detect, status-change and ready pins
`default_nettype none
module ssms_card_model (
   input wire logic clock,
   input wire logic present,
   input wire logic sts_level,
   input wire logic ready_level,
   output logic detect_one,
   output logic detect_two,
   output logic sts_pin,
   output logic ready_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Pin drive
   // Detect lines are pulled up with no card, so an empty socket reads high
   always_ff @(posedge clock) begin
      detect_one <= ~present;
      detect_two <= ~present;
      sts_pin <= sts_level;
      ready_pin <= ready_level;
   end
endmodule : ssms_card_model
`default_nettype wire

//--- verification/test_socket_status_mask_and_state.sv
// Self-checking bench for the socket mask and present-state register bank
`default_nettype none
module test_socket_status_mask_and_state;
   timeunit 1ns;
   timeprecision 100ps;
   import ssms_pkg::*;
   // ==========================================================
   // Stimulus and observation
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic bus_b = 1'b1;
   logic pme = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic fvo = 1'b0;
   logic interr = 1'b0;
   logic powered = 1'b0;
   logic present = 1'b0;
   logic sts = 1'b0;
   logic rdy = 1'b0;
   logic [3:0] pulses = 4'h0; // Force, insert, bad supply, data loss
   logic [SSMS_ADDR_W-1:0] addr = 8'h00;
   logic [SSMS_DATA_W-1:0] wdata = 32'h0;
   logic [SSMS_DATA_W-1:0] fdata = 32'h0;
   logic [SSMS_EVENT_W-1:0] ev = 4'h0;
   logic [SSMS_VOLT_W-1:0] volts = 4'h0;
   logic [2:0] kinds = 3'h0;
   wire logic det1;
   wire logic det2;
   wire logic stsp;
   wire logic rdyp;
   wire logic [SSMS_DATA_W-1:0] rdata;
   wire logic irq;
   int fails = 0;
   int check_count = 0;
   // Interrupt table: mask, events, expected level per row
   logic [3:0] tm [9] = '{4'h0, 4'h1, 4'h1, 4'h6, 4'h6, 4'h2, 4'h4, 4'h8, 4'h7};
   logic [3:0] tev [9] = '{4'hf, 4'h1, 4'he, 4'h2, 4'h4, 4'h6, 4'h6, 4'h8, 4'h8};
   logic [8:0] texp = 9'h09a;
   ssms_top ssms_top_i (
      .clock(clock), .rst_b(rst_b), .pci_bus_reset_b(bus_b), .pme_enable(pme),
      .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wr_data(wdata), .reg_rd_data(rdata),
      .event_bits(ev), .force_wr(pulses[0]), .force_data(fdata), .five_volt_override(fvo),
      .card_inserted(pulses[1]), .interrogating(interr), .sensed_card_volts(volts),
      .sensed_cardbus_card(kinds[0]), .sensed_16bit_card(kinds[1]), .sensed_not_a_card(kinds[2]),
      .socket_powered_flag(powered), .invalid_supply_request(pulses[2]),
      .removal_data_loss(pulses[3]), .detect_line_one_pin(det1), .detect_line_two_pin(det2),
      .status_change_line_pin(stsp), .ready_line_pin(rdyp), .socket_change_interrupt(irq)
   );
   ssms_card_model ssms_card_model_i (
      .clock(clock), .present(present), .sts_level(sts), .ready_level(rdy),
      .detect_one(det1), .detect_two(det2), .sts_pin(stsp), .ready_pin(rdyp)
   );
   // ==========================================================
   // Clock and watchdog
   initial begin
      forever begin
         #5 clock = ~clock;
      end
   end
   // A hang counts as a mismatch rather than running forever
   initial begin
      #100000;
      fails++;
      give_verdict;
   end
   // ==========================================================
   // Access and compare tasks
   task automatic note(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : note
   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : write_reg
   // Read data lands on the same edge that takes the strobe
   task automatic check_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      note("read data", exp & m, rdata & m);
      @(posedge clock);
   endtask : check_read
   task automatic check_irq(input logic exp);
      repeat (3) @(posedge clock);
      @(negedge clock);
      note("interrupt", {31'h0, exp}, {31'h0, irq});
      @(posedge clock);
   endtask : check_irq
   task automatic pulse(input int b);
      @(posedge clock);
      pulses[b] <= 1'b1;
      @(posedge clock);
      pulses <= 4'h0;
   endtask : pulse
   // Bus reset pin passes a two-flop synchroniser, so hold it and let it settle
   task automatic bus_reset;
      @(posedge clock);
      bus_b <= 1'b0;
      repeat (4) @(posedge clock);
      bus_b <= 1'b1;
      repeat (5) @(posedge clock);
   endtask : bus_reset
   task automatic give_verdict;
      if (fails == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      repeat (6) @(posedge clock);
      check_read(8'h04, 32'hffff_ffff, 32'h0);
      check_read(8'h08, 32'hffff_ff0f, 32'h3000_0006);
      write_reg(8'h04, 32'hffff_ffff);
      check_read(8'h04, 32'hffff_ffff, 32'h0000_000f);
      check_read(8'h10, 32'hffff_ffff, 32'h0);
      for (int i = 0; i < 9; i++) begin
         write_reg(8'h04, {28'h0, tm[i]});
         @(posedge clock);
         ev <= tev[i];
         check_irq(texp[i]);
      end
      ev <= 4'h0;
      sts <= 1'b1;
      powered <= 1'b1;
      rdy <= 1'b1;
      repeat (4) @(posedge clock);
      check_read(8'h08, 32'h0000_0049, 32'h0000_0049);
      interr <= 1'b1;
      present <= 1'b1;
      repeat (6) @(posedge clock);
      check_read(8'h08, 32'h6, 32'h6);
      interr <= 1'b0;
      repeat (6) @(posedge clock);
      check_read(8'h08, 32'h6, 32'h0);
      volts <= 4'h5;
      repeat (2) @(posedge clock);
      check_read(8'h08, 32'h3c00, 32'h0);
      pulse(1);
      check_read(8'h08, 32'h3c00, 32'h1400);
      volts <= 4'ha;
      fdata <= 32'h0000_0820;
      pulse(0);
      check_read(8'h08, 32'h3c20, 32'h1c20);
      fdata <= 32'hc000_0000;
      pulse(0);
      check_read(8'h08, 32'hf000_3c00, 32'hd000_1c00);
      fvo <= 1'b1;
      repeat (2) @(posedge clock);
      check_read(8'h08, 32'h1000_0000, 32'h0);
      pulse(2);
      pulse(3);
      check_read(8'h08, 32'h300, 32'h300);
      write_reg(8'h04, 32'hf);
      pme <= 1'b1;
      bus_reset;
      check_read(8'h04, 32'hffff_ffff, 32'h7);
      check_read(8'h08, 32'hf000_3f00, 32'h2000_1f00);
      pme <= 1'b0;
      bus_reset;
      check_read(8'h04, 32'hffff_ffff, 32'h0);
      check_read(8'h08, 32'h3f00, 32'h0);
      give_verdict;
   end
endmodule : test_socket_status_mask_and_state
`default_nettype wire
